// ===== include/sub_shift_pkg.sv
/*
 holds the shared constants and carrier types of the subtract and shift
 datapath. assumes a 32-bit register file and an 8-bit immediate field.
*/
package sub_shift_pkg;

	localparam int DATA_W = 32;
	localparam int IMM_W = 8;
	localparam int SHAMT_W = 5;
	localparam int SIGN_BIT = 31;
	localparam int REG_IDX_W = 8;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

	// -----------------------------------------------------------------
	// operation codes
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		shift_right_zero_fill = 4'h0,
		subtract_plain = 4'h1,
		subtract_signed_checked = 4'h2,
		subtract_unsigned_checked = 4'h3,
		subtract_with_carry_in = 4'h4,
		subtract_carry_signed_checked = 4'h5,
		subtract_carry_unsigned_checked = 4'h6,
		reverse_subtract = 4'h7,
		reverse_signed_checked = 4'h8,
		reverse_unsigned_checked = 4'h9,
		reverse_subtract_carry_in = 4'hA,
		reverse_carry_signed_checked = 4'hB,
		reverse_carry_unsigned_checked = 4'hC
	} alu_op_e;

	typedef struct packed {
		logic overflow;
		logic negative;
		logic zero;
		logic carry;
	} status_flags_s;

	typedef struct packed {
		logic valid;
		alu_op_e op;
		logic imm_select;
		logic [IMM_W-1:0] immediate;
		logic [DATA_W-1:0] first_operand;
		logic [DATA_W-1:0] second_register;
		logic [REG_IDX_W-1:0] target_register;
	} alu_request_s;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] value;
		logic [REG_IDX_W-1:0] target_register;
		logic out_of_range;
	} alu_result_s;

endpackage

// ===== design/sub_adder.sv
/*
 holds the 32-bit adder with carry in and the derived carry and signed overflow outputs.
 assumes the caller has already inverted whichever operand is subtracted.
*/
`timescale 1ns/1ps
module sub_adder #(
	parameter int WIDTH = 32
)(
	input wire logic [WIDTH-1:0] addend_a,
	input wire logic [WIDTH-1:0] addend_b,
	input wire logic carry_in,
	output logic [WIDTH-1:0] sum,
	output logic carry_out,
	output logic signed_overflow
);
	logic [WIDTH:0] wide_sum;

	always_comb
	begin
		wide_sum = {1'b0, addend_a} + {1'b0, addend_b}
			+ {{WIDTH{1'b0}}, carry_in};
		sum = wide_sum[WIDTH-1:0];
		carry_out = wide_sum[WIDTH];
		// same-sign inputs giving an opposite-sign sum
		signed_overflow = (addend_a[WIDTH-1] == addend_b[WIDTH-1])
			&& (sum[WIDTH-1] != addend_a[WIDTH-1]);
	end
endmodule

// ===== design/subtract_shift_alu.sv
/*
 holds the subtract family and logical right shift execution stage.
 assumes the decoder presents one request per cycle, held for one cycle,
 and that the trap logic acts on out_of_range of the registered result.
*/
`timescale 1ns/1ps
module subtract_shift_alu #(
	parameter int WIDTH = sub_shift_pkg::DATA_W
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire sub_shift_pkg::alu_request_s request,
	output sub_shift_pkg::alu_result_s result,
	output sub_shift_pkg::status_flags_s flags
);
	logic [WIDTH-1:0] operand_two;
	logic [WIDTH-1:0] addend_a;
	logic [WIDTH-1:0] addend_b;
	logic carry_in;
	logic [WIDTH-1:0] sum;
	logic carry_out;
	logic signed_overflow;
	logic is_shift;
	logic signed_check;
	logic unsigned_check;
	logic [WIDTH-1:0] shifted;
	logic [WIDTH-1:0] next_value;
	logic next_trap;
	sub_shift_pkg::status_flags_s next_flags;

	// ---------------------------------------------------------------
	// operand selection
	// ---------------------------------------------------------------
	always_comb
	begin
		if (request.imm_select)
			operand_two = {{(WIDTH - sub_shift_pkg::IMM_W){1'b0}},
				request.immediate};
		else
			operand_two = request.second_register;
	end

	// ---------------------------------------------------------------
	// adder input steering
	// ---------------------------------------------------------------
	always_comb
	begin
		addend_a = request.first_operand;
		addend_b = ~operand_two;
		carry_in = 1'b1;
		is_shift = 1'b0;
		signed_check = 1'b0;
		unsigned_check = 1'b0;
		case (request.op)
			sub_shift_pkg::shift_right_zero_fill:
				is_shift = 1'b1;
			// a plus not b plus one
			sub_shift_pkg::subtract_plain:
				carry_in = 1'b1;
			sub_shift_pkg::subtract_signed_checked:
				signed_check = 1'b1;
			sub_shift_pkg::subtract_unsigned_checked:
				unsigned_check = 1'b1;
			sub_shift_pkg::subtract_with_carry_in:
				carry_in = flags.carry;
			sub_shift_pkg::subtract_carry_signed_checked:
			begin
				carry_in = flags.carry;
				signed_check = 1'b1;
			end
			sub_shift_pkg::subtract_carry_unsigned_checked:
			begin
				carry_in = flags.carry;
				unsigned_check = 1'b1;
			end
			sub_shift_pkg::reverse_subtract:
			begin
				addend_a = operand_two;
				addend_b = ~request.first_operand;
			end
			sub_shift_pkg::reverse_signed_checked:
			begin
				addend_a = operand_two;
				addend_b = ~request.first_operand;
				signed_check = 1'b1;
			end
			sub_shift_pkg::reverse_unsigned_checked:
			begin
				addend_a = operand_two;
				addend_b = ~request.first_operand;
				unsigned_check = 1'b1;
			end
			sub_shift_pkg::reverse_subtract_carry_in:
			begin
				addend_a = operand_two;
				addend_b = ~request.first_operand;
				carry_in = flags.carry;
			end
			sub_shift_pkg::reverse_carry_signed_checked:
			begin
				addend_a = operand_two;
				addend_b = ~request.first_operand;
				carry_in = flags.carry;
				signed_check = 1'b1;
			end
			sub_shift_pkg::reverse_carry_unsigned_checked:
			begin
				addend_a = operand_two;
				addend_b = ~request.first_operand;
				carry_in = flags.carry;
				unsigned_check = 1'b1;
			end
			default:
				is_shift = 1'b1;
		endcase
	end

	sub_adder #(
		.WIDTH(WIDTH)
	) adder (
		.addend_a(addend_a),
		.addend_b(addend_b),
		.carry_in(carry_in),
		.sum(sum),
		.carry_out(carry_out),
		.signed_overflow(signed_overflow)
	);

	// ---------------------------------------------------------------
	// result and trap
	// ---------------------------------------------------------------
	always_comb
	begin
		shifted = request.first_operand
			>> operand_two[sub_shift_pkg::SHAMT_W-1:0];
		next_value = is_shift ? shifted : sum;
		next_trap = (signed_check && signed_overflow)
			|| (unsigned_check && !carry_out);
	end

	always_comb
	begin
		// all four flags from the addition
		next_flags.overflow = signed_overflow;
		next_flags.negative = sum[sub_shift_pkg::SIGN_BIT];
		next_flags.zero = (sum == '0);
		next_flags.carry = carry_out;
	end

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			result.valid <= 1'b0;
			result.value <= sub_shift_pkg::RESULT_RESET;
			result.target_register <= '0;
			result.out_of_range <= 1'b0;
		end
		else
		begin
			result.valid <= request.valid;
			result.value <= next_value;
			result.target_register <= request.target_register;
			result.out_of_range <= request.valid && next_trap;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			flags <= sub_shift_pkg::FLAGS_RESET;
		else if (request.valid && !is_shift)
			flags <= next_flags;
	end
endmodule

// ===== verification/alu_monitor.sv
/*
 checker for the subtract and shift stage.
 sees only the top ports; bound in after the module.
*/
`timescale 1ns/1ps
module alu_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire sub_shift_pkg::alu_request_s request,
	input wire sub_shift_pkg::alu_result_s result,
	input wire sub_shift_pkg::status_flags_s flags
);
	// ----
	// helpers
	// ----
	logic sh;
	logic chk;
	logic [31:0] sh_val;
	logic [31:0] imm_val;
	logic [31:0] sub_val;
	assign sh = request.op == sub_shift_pkg::shift_right_zero_fill;
	assign chk = request.valid && request.op inside {2, 3, 5, 6, 8, 9, 11, 12};
	assign sh_val = request.first_operand >> request.second_register[4:0];
	assign imm_val = request.first_operand >> request.immediate[4:0];
	assign sub_val = request.first_operand - request.second_register;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_one_cycle: assert property (request.valid |=> result.valid)
		else $error("result missing");
	a_no_extra: assert property (!request.valid |=> !result.valid)
		else $error("stray result");
	a_target_kept: assert property (request.valid |=>
		result.target_register == $past(request.target_register))
		else $error("wrong target");
	a_shift_reg: assert property (request.valid && sh &&
		!request.imm_select |=> result.value == $past(sh_val))
		else $error("bad shift");
	a_shift_imm: assert property (request.valid && sh &&
		request.imm_select |=> result.value == $past(imm_val))
		else $error("bad immediate shift");
	a_plain_sub: assert property (request.valid && !request.imm_select &&
		request.op == sub_shift_pkg::subtract_plain |=>
		result.value == $past(sub_val)) else $error("bad difference");
	a_shift_flags: assert property (request.valid && sh |=> $stable(flags))
		else $error("shift moved flags");
	a_zero_flag: assert property (request.valid && !sh |=>
		flags.zero == (result.value == 32'h0)) else $error("bad zero flag");
	a_neg_flag: assert property (request.valid && !sh |=>
		flags.negative == result.value[31]) else $error("bad sign flag");
	a_trap_source: assert property (result.out_of_range |-> $past(chk))
		else $error("trap from unchecked op");
	cover property (result.out_of_range);
	cover property (request.valid && sh);
	cover property (request.valid ##1 request.valid);
endmodule
bind subtract_shift_alu alu_monitor mon (.clk_sys(clk_sys), .rst(rst),
	.request(request), .result(result), .flags(flags));

// ===== verification/op_source.sv
/*
 decoder and register file model feeding the stage.
 drives one request per call, just after a rising edge.
*/
`timescale 1ns/1ps
module op_source (
	input wire logic clk_sys,
	output sub_shift_pkg::alu_request_s request
);
	initial request = '0;
	task automatic issue(input sub_shift_pkg::alu_request_s r);
		@(posedge clk_sys);
		request <= r;
	endtask
	// idle fields inverted so stale operands never look valid
	task automatic idle();
		sub_shift_pkg::alu_request_s r;
		r = ~request;
		r.valid = 1'b0;
		@(posedge clk_sys);
		request <= r;
	endtask
endmodule

// ===== verification/tb_top.sv
/*
 self-checking bench for the subtract and shift stage.
 uses op_source as decoder model; alu_monitor is bound in.
*/
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [31:0] value;
		logic [7:0] target;
		logic trap;
		sub_shift_pkg::status_flags_s flags;
	} expect_s;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	sub_shift_pkg::alu_request_s request;
	sub_shift_pkg::alu_result_s result;
	sub_shift_pkg::status_flags_s flags;
	sub_shift_pkg::status_flags_s model_flags = '0;
	expect_s notes[$];
	expect_s exp_n;
	logic [31:0] v;
	int fail_count = 0;
	int samples_checked = 0;
	int seed = 68881;
	always #2 clk_sys = ~clk_sys;
	op_source src (.clk_sys(clk_sys), .request(request));
	subtract_shift_alu uut (.clk_sys(clk_sys), .rst(rst), .request(request),
		.result(result), .flags(flags));
	task automatic check(input expect_s got, input expect_s exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// driver and reference
	// ----
	task automatic run(input logic [3:0] op, input logic [31:0] a, b,
		input logic sel);
		sub_shift_pkg::alu_request_s r;
		logic [31:0] x, y, bo;
		logic [32:0] s;
		logic c;
		expect_s e;
		bo = sel ? {24'h0, b[7:0]} : b;
		r = {1'b1, sub_shift_pkg::alu_op_e'(op), sel, b[7:0], a, b,
			a[7:0] ^ b[7:0]};
		e.target = r.target_register;
		e.flags = model_flags;
		e.trap = 1'b0;
		e.value = a >> bo[4:0];
		if (op != 4'h0)
		begin
			x = (op > 4'h6) ? bo : a;
			y = (op > 4'h6) ? a : bo;
			c = (op inside {4, 5, 6, 10, 11, 12}) ? model_flags.carry : 1'b1;
			s = {1'b0, x} + {1'b0, ~y} + {32'h0, c};
			e.value = s[31:0];
			e.flags = {x[31] != y[31] && s[31] != x[31], s[31],
				s[31:0] == 32'h0, s[32]};
			e.trap = (op inside {2, 5, 8, 11}) ? e.flags.overflow :
				(op inside {3, 6, 9, 12}) && !s[32];
			model_flags = e.flags;
		end
		notes.push_back(e);
		src.issue(r);
	endtask
	always @(negedge clk_sys)
		if (result.valid === 1'b1)
		begin
			exp_n = (notes.size() > 0) ? notes.pop_front() : 'x;
			check({result.value, result.target_register, result.out_of_range,
				flags}, exp_n);
		end
	initial
	begin
		#20000;
		fail_count++;
		end_of_test();
	end
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		// overflow, borrow, zero and maximum 31-bit shift for every code
		for (int i = 0; i < 13; i++)
		begin
			run(4'(i), 32'h8000_0000, 32'h1, 1'b0);
			run(4'(i), 32'h0, 32'h0, 1'b1);
			run(4'(i), 32'h7, 32'hFFFF_FF1F, 1'b1);
		end
		$display("directed corners done");
		repeat (300)
		begin
			v = $random(seed);
			run(4'(v % 13), $random(seed), $random(seed), v[20]);
		end
		$display("random ops done");
		src.idle();
		repeat (3) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		model_flags = '0;
		run(4'h4, 32'h9, 32'h2, 1'b0);
		src.idle();
		repeat (3) @(posedge clk_sys);
		$display("reset recovery done");
		end_of_test();
	end
endmodule
